// [inc/pbseq_pkg.sv]
package pbseq_pkg;
  localparam int unsigned CLK_FREQ_HZ     = 125_000_000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYCLES     = CLK_FREQ_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TURN_ON_DB_MS   = 32;
  localparam int unsigned TURN_OFF_DB_MS  = 32;
  localparam int unsigned REQ_MIN_MS      = 32;
  localparam int unsigned FORCED_BASE_MS  = 64;
  localparam int unsigned BLANK_MS        = 512;
  localparam int unsigned LOCKOUT_MS      = 256;
  localparam int unsigned MS_W            = 16;
  localparam logic [1:0]  SYNC_RESET      = 2'h3;
endpackage

// [inc/ms_timer_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ms_timer_if;
  logic        clear;
  logic        tick;
  logic [15:0] elapsed;
  modport owner (output clear, input tick, input elapsed);
  modport timer (input clear, output tick, output elapsed);
endinterface
`default_nettype wire

// [core/ms_time_base.sv]
`timescale 1ns/1ps
`default_nettype none
module ms_time_base #(
  parameter int unsigned TICK_CYCLES = pbseq_pkg::TICK_CYCLES
) (
  input  wire logic   core_clk, // system clock
  input  wire logic   rst_n,    // async reset, active low
  ms_timer_if.timer   tm        // clear in, tick and elapsed out
);
  logic [31:0] prescale;
  logic [15:0] elapsed;
  logic        tick;
  wire         wrap = (prescale == 32'(TICK_CYCLES - 1));
  // free-running tick; clear zeroes the ms count only, so first count
  // after a clear may come up to 1 ms early (within the allowed spread)
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 32'h0000_0000;
      tick     <= 1'b0;
      elapsed  <= 16'h0000;
    end else begin
      prescale <= wrap ? 32'h0000_0000 : prescale + 32'h0000_0001;
      tick     <= wrap;
      if (tm.clear)
        elapsed <= 16'h0000;
      else if (wrap && elapsed != 16'hffff)
        elapsed <= elapsed + 16'h0001;
    end
  end
  assign tm.tick    = tick;
  assign tm.elapsed = elapsed;
endmodule
`default_nettype wire

// [core/pushbutton_power_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RL1] when on, shutdown request goes low after 32 ms continuous button low
// [RL2] request stays low at least 32 ms, then while button is held
// [RL3] button held past forced-off time releases enable and request at once
// [RL4] forced-off base time is 64 ms from button fall to enable release
// [RL5] forced-off time extended by a configurable extra duration
// [RL6] turn-on debounce 32 ms plus configurable extra duration
// [RL7] active-high variant drives enable high after valid turn-on; the pin is released to its pull-up instead
// [RL8] active-low variant drives enable low on, returns high on release
// [RL9] 512 ms blanking after enable: kill and button ignored
// [RL10] kill still low at blanking end releases enable, aborting power-on
// [RL11] host must raise kill before blanking ends, else power goes off
// [RL12] after blanking, kill low releases enable
// [RL13] host holds kill low at least 30 us to shut power off
// [RL14] host finishes housekeeping after request, then drives kill low
// [RL15] button ignored during lockout after enable release
// [RL16] lockout lasts 256 ms from release until new turn-on accepted
// [RL17] button high before a debounce completes restarts that timer
// [RL18] timers from one time base; durations parameters; inputs synchronised (the extra-time inputs are not)
module pushbutton_power_sequencer #(
  parameter bit          ACTIVE_LOW_ENABLE = 1'b0,
  parameter int unsigned TURN_ON_DB_MS     = pbseq_pkg::TURN_ON_DB_MS,
  parameter int unsigned TURN_OFF_DB_MS    = pbseq_pkg::TURN_OFF_DB_MS,
  parameter int unsigned REQ_MIN_MS        = pbseq_pkg::REQ_MIN_MS,
  parameter int unsigned FORCED_BASE_MS    = pbseq_pkg::FORCED_BASE_MS,
  parameter int unsigned BLANK_MS          = pbseq_pkg::BLANK_MS,
  parameter int unsigned LOCKOUT_MS        = pbseq_pkg::LOCKOUT_MS,
  parameter int unsigned TICK_CYCLES       = pbseq_pkg::TICK_CYCLES
) (
  input  wire logic        core_clk,              // 125 MHz clock
  input  wire logic        rst_n,                 // async reset, low
  input  wire logic        pushbutton_n,          // button pin, low pressed
  input  wire logic        power_kill_n,          // host kill, low kills
  input  wire logic [15:0] turn_on_extra_time,    // added on debounce, ms
  input  wire logic [15:0] power_down_extra_time, // added forced-off, ms
  output logic             power_en_o,            // enable pin level driven
  output logic             power_en_oe,           // open-drain pull enable
  output logic             shutdown_req_o,        // request pin level
  output logic             shutdown_req_oe,       // high while pulling low
  output logic             powered_on             // status: enable asserted
);
  // OFF waits for a press, ARM times the turn-on press, BLANK is the
  // window after turn-on with both inputs ignored, RUN watches for a
  // press or a kill, REQ holds the shutdown request, LOCKOUT keeps
  // the button away until the supply has had time to collapse
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_ARM     = 3'b001,
    ST_BLANK   = 3'b010,
    ST_RUN     = 3'b011,
    ST_REQ     = 3'b100,
    ST_LOCKOUT = 3'b101
  } state_e;

  state_e      state;
  state_e      next_state;
  logic [1:0]  pb_sync;
  logic [1:0]  kill_sync;
  logic [15:0] down_ms;
  logic        req_active;
  logic [15:0] next_down_ms;
  logic        next_req_active;
  logic        tmr_clear;

  // one shared time base serves every phase; elapsed times one phase at a
  // time, and the press length in RUN and REQ keeps its own count, down_ms
  ms_timer_if tmr ();

  ms_time_base #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_time_base (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tm       (tmr.timer)
  );

  // two-stage synchronisers: logic reads only the second stage, the
  // first may still be settling from a metastable capture
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pb_sync   <= pbseq_pkg::SYNC_RESET;
      kill_sync <= pbseq_pkg::SYNC_RESET;
    end else begin
      pb_sync   <= {pb_sync[0], pushbutton_n};   // RL18
      kill_sync <= {kill_sync[0], power_kill_n}; // RL18
    end
  end

  // active-high views of the synchronised pins
  wire        pb_low   = ~pb_sync[1];
  wire        kill_low = ~kill_sync[1];
  wire [15:0] elapsed  = tmr.elapsed;
  wire [16:0] on_limit = 17'(TURN_ON_DB_MS) + {1'b0, turn_on_extra_time};
  // extra times are meant as static straps and are not synchronised
  wire [16:0] off_limit =
    17'(FORCED_BASE_MS) + {1'b0, power_down_extra_time}; // RL5
  wire        on_done   = ({1'b0, elapsed} >= on_limit);      // RL6
  wire        forced    = pb_low && ({1'b0, down_ms} >= off_limit); // RL4
  wire        blank_end = (elapsed >= 16'(BLANK_MS));         // RL9
  wire        lock_end  = (elapsed >= 16'(LOCKOUT_MS));       // RL16
  wire        off_db    = (down_ms >= 16'(TURN_OFF_DB_MS));   // RL1
  wire        req_min   = (elapsed >= 16'(REQ_MIN_MS));       // RL2
  assign tmr.clear = tmr_clear;

  // press length in ms, restarted by every release of the button
  wire [15:0] down_count =
    !pb_low ? 16'h0000 :                                    // RL17
    (tmr.tick && down_ms != 16'hffff) ? down_ms + 16'h0001 : down_ms;
  wire        kill_release   = kill_low;                     // RL12
  wire        any_release    = kill_release || forced;       // RL3

  // next-state logic; every path starts from the held values
  always_comb begin
    next_state      = state;
    next_down_ms    = down_ms;
    next_req_active = req_active;
    tmr_clear       = 1'b0;
    unique case (state)
      ST_OFF: begin
        // held clear so the turn-on press is timed from zero
        tmr_clear = 1'b1;
        if (pb_low)
          next_state = ST_ARM;
      end
      ST_ARM: begin
        // a bounce back high throws the whole press away
        if (!pb_low) begin
          next_state = ST_OFF; // RL17
        end else if (on_done) begin
          next_state = ST_BLANK; // RL7
          tmr_clear  = 1'b1;
        end
      end
      ST_BLANK: begin
        next_down_ms = 16'h0000; // button ignored, RL9
        // kill is looked at once, when the window closes
        if (blank_end) begin
          tmr_clear = 1'b1;
          next_state = kill_low ? ST_LOCKOUT : ST_RUN; // RL10
        end
      end
      ST_RUN: begin
        next_down_ms = down_count;
        if (any_release) begin
          next_state      = ST_LOCKOUT; // RL12 RL3
          next_req_active = 1'b0;
          tmr_clear       = 1'b1;
        end else if (off_db) begin
          next_state      = ST_REQ; // RL1
          next_req_active = 1'b1;
          tmr_clear       = 1'b1;
        end
      end
      ST_REQ: begin
        // the request outlives a short tap, and a long hold keeps it
        next_down_ms = down_count;
        if (any_release) begin
          next_state      = ST_LOCKOUT; // RL3 RL12
          next_req_active = 1'b0;
          tmr_clear       = 1'b1;
        end else if (req_min && !pb_low) begin
          next_state      = ST_RUN; // RL2
          next_req_active = 1'b0;
        end
      end
      ST_LOCKOUT: begin
        next_down_ms = 16'h0000;
        // the supply needs this time to collapse before a restart
        if (lock_end)
          next_state = ST_OFF; // RL15
      end
      default: begin
        next_state      = ST_OFF;
        next_req_active = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_OFF;
      down_ms    <= 16'h0000;
      req_active <= 1'b0;
    end else begin
      state      <= next_state;
      down_ms    <= next_down_ms;
      req_active <= next_req_active;
    end
  end

  // next_on is looked at one edge early so that the pin registers line
  // up with state and carry no extra cycle of lag
  wire next_on = (next_state == ST_BLANK) || (next_state == ST_RUN) ||
                 (next_state == ST_REQ);

  // both variants are open drain: the pin only ever sinks, so its drive
  // value is tied low and the variant only decides when to pull
  wire next_pull_hi_variant = ~next_on; // RL7
  wire next_pull_lo_variant = next_on;  // RL8
  wire next_en_oe           = ACTIVE_LOW_ENABLE ? next_pull_lo_variant :
                                                  next_pull_hi_variant;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_en_oe     <= ~ACTIVE_LOW_ENABLE;
      shutdown_req_oe <= 1'b0;
      powered_on      <= 1'b0;
    end else begin
      power_en_oe     <= next_en_oe;      // RL7 RL8
      shutdown_req_oe <= next_req_active; // RL2
      powered_on      <= next_on;
    end
  end

  // a released pin floats to its external pull-up level
  assign power_en_o     = 1'b0;
  assign shutdown_req_o = 1'b0;
endmodule
`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       core_clk,        // clock
  input  wire logic       powered_on,      // host supplied
  input  wire logic       shutdown_req_oe, // request seen
  input  wire logic [1:0] mode,            // 0 obey, 1 deaf, 2 stuck
  output logic            power_kill_n     // kill drive
);
  // an unpowered host cannot hold kill up
  initial power_kill_n = 1'h0;
  always begin
    @(posedge core_clk iff powered_on);
    repeat (400) @(posedge core_clk);
    if (mode != 2'h2) power_kill_n <= 1'h1;
    @(posedge core_clk iff ((shutdown_req_oe && mode == 2'h0) || !powered_on));
    if (powered_on) begin
      repeat (200) @(posedge core_clk);
      power_kill_n <= 1'h0;
      repeat (3750) @(posedge core_clk);
    end
    power_kill_n <= 1'h0;
  end
endmodule
`default_nettype wire

// [tb/pbseq_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module pbseq_sva #(
  parameter bit          ACTIVE_LOW_ENABLE = 1'h0,
  parameter int unsigned TICK_CYCLES       = 4
) (
  input wire logic        core_clk,              // clock
  input wire logic        rst_n,                 // reset
  input wire logic        pushbutton_n,          // button
  input wire logic        power_kill_n,          // kill
  input wire logic [15:0] turn_on_extra_time,    // ms
  input wire logic [15:0] power_down_extra_time, // ms
  input wire logic        power_en_oe,           // enable pull
  input wire logic        shutdown_req_oe,       // request pull
  input wire logic        powered_on             // status
);
  localparam int T = TICK_CYCLES;
  localparam int REQ_HOLD = 31 * TICK_CYCLES;
  int press;
  int on_t;
  int off_t;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // off_t starts high: no lockout holds back the first turn-on
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) begin
      press <= 0;
      on_t <= 0;
      off_t <= 99999;
    end else begin
      press <= pushbutton_n ? 0 : press + 1;
      on_t <= powered_on ? on_t + 1 : 0;
      off_t <= powered_on ? 0 : off_t + 1;
    end
  sequence s_req_held;
    (shutdown_req_oe || !powered_on) throughout ##REQ_HOLD 1'h1;
  endsequence
  a_pin_polarity: assert property (power_en_oe ==
    (powered_on == ACTIVE_LOW_ENABLE)) else $error("enable level wrong");
  a_on_debounce: assert property ($rose(powered_on) |->
    press >= (31 + turn_on_extra_time) * T &&
    press <= (33 + turn_on_extra_time) * T + 6) else $error("turn-on time");
  a_req_debounce: assert property ($rose(shutdown_req_oe) |->
    press >= 31 * T && press <= 33 * T + 6) else $error("request time");
  a_req_width: assert property ($rose(shutdown_req_oe) |->
    s_req_held) else $error("request too short");
  a_forced_time: assert property ($fell(powered_on) && power_kill_n |->
    press >= (63 + power_down_extra_time) * T) else $error("forced off early");
  a_blank_hold: assert property (powered_on && on_t < 510 * T |=>
    powered_on) else $error("enable dropped while blanked");
  a_kill_release: assert property (powered_on && on_t > 516 * T &&
    !power_kill_n |-> ##[1:8] !powered_on) else $error("kill ignored");
  a_lockout_gap: assert property ($rose(powered_on) |->
    off_t >= 255 * T) else $error("turn-on inside lockout");
endmodule
bind pushbutton_power_sequencer pbseq_sva #(
  .ACTIVE_LOW_ENABLE (ACTIVE_LOW_ENABLE),
  .TICK_CYCLES       (TICK_CYCLES)
) u_sva (
  .core_clk, .rst_n, .pushbutton_n, .power_kill_n, .turn_on_extra_time,
  .power_down_extra_time, .power_en_oe, .shutdown_req_oe, .powered_on);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int T = 4;
  logic        core_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        pushbutton_n = 1'h1;
  logic [15:0] turn_on_extra_time = 16'h0000;
  logic [15:0] power_down_extra_time = 16'h0000;
  logic [1:0]  mode = 2'h0;
  wire logic   power_kill_n;
  wire logic   power_en_oe;
  wire logic   shutdown_req_oe;
  wire logic   powered_on;
  wire logic   power_en_o;
  wire logic   shutdown_req_o;
  wire logic   en_oe_inv;
  int          seed = 76;
  int          n_mismatch;
  int          comparisons;
  int          cycles;
  int          n;
  always #4 core_clk = ~core_clk;
  pushbutton_power_sequencer #(.TICK_CYCLES(T)) u_dut (
    .core_clk, .rst_n, .pushbutton_n, .power_kill_n, .turn_on_extra_time,
    .power_down_extra_time, .power_en_o, .power_en_oe, .shutdown_req_o,
    .shutdown_req_oe, .powered_on);
  pushbutton_power_sequencer #(.ACTIVE_LOW_ENABLE(1'b1), .TICK_CYCLES(T))
    u_dut_inv (
    .core_clk, .rst_n, .pushbutton_n, .power_kill_n, .turn_on_extra_time,
    .power_down_extra_time, .power_en_o(), .power_en_oe(en_oe_inv),
    .shutdown_req_o(), .shutdown_req_oe(), .powered_on());
  host_model u_host (.core_clk, .powered_on, .shutdown_req_oe, .mode,
    .power_kill_n);
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  // set the button, count edges until the chosen output reaches lvl
  task automatic hold(logic btn, bit req, logic lvl, int lim);
    pushbutton_n <= btn;
    n = 0;
    @(negedge core_clk);
    while ((req ? shutdown_req_oe : powered_on) !== lvl && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    pushbutton_n <= 1'h1;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic power_up;
    hold(1'h0, 1'h0, 1'h1, 2000);
    check("turn_on", n >= (31 + turn_on_extra_time) * T &&
      n <= (33 + turn_on_extra_time) * T + 8, 1);
    check("enable_on", power_en_oe, 1'h0);
    check("enable_inv", en_oe_inv, 1'h1);
    check("en_drive", power_en_o, 1'h0);
    check("req_drive", shutdown_req_o, 1'h0);
    $display("test power_up done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
    turn_on_extra_time <= {14'h0000, 2'($random(seed))};
    power_down_extra_time <= {14'h0000, 2'($random(seed))};
    hold(1'h0, 1'h0, 1'h1, 20 * T);
    check("short_press", powered_on, 1'h0);
    check("enable_off", power_en_oe, 1'h1);
    check("enable_inv_off", en_oe_inv, 1'h0);
    power_up;
    repeat (520 * T) @(posedge core_clk);
    hold(1'h0, 1'h1, 1'h1, 300);
    check("req_time", n >= 31 * T && n <= 33 * T + 8, 1);
    hold(1'h1, 1'h0, 1'h0, 500);
    check("kill_off", powered_on, 1'h0);
    hold(1'h0, 1'h0, 1'h1, 200 * T);
    check("lockout", powered_on, 1'h0);
    $display("test kill_and_lockout done");
    // the host keeps kill low a while after its own shutdown
    repeat (3800) @(posedge core_clk);
    mode <= 2'h1;
    power_up;
    repeat (520 * T) @(posedge core_clk);
    hold(1'h0, 1'h0, 1'h0, 400);
    check("forced_off", n >= (63 + power_down_extra_time) * T &&
      n <= (65 + power_down_extra_time) * T + 8, 1);
    check("req_gone", shutdown_req_oe, 1'h0);
    $display("test forced_off done");
    repeat (300 * T) @(posedge core_clk);
    mode <= 2'h2;
    power_up;
    hold(1'h1, 1'h0, 1'h0, 600 * T);
    check("abort", n >= 509 * T && n <= 514 * T, 1);
    $display("test abort done");
    close_out;
  end
endmodule
`default_nettype wire
